// file: verilog/flash_cmd_pkg.sv
// package of opcodes, status bit positions, reset values and timing counts
package flash_cmd_pkg;
  // opcodes
  localparam logic [7:0] op_write_enable     = 8'h06;
  localparam logic [7:0] op_volatile_enable  = 8'h50;
  localparam logic [7:0] op_write_disable    = 8'h04;
  localparam logic [7:0] op_read_status_1    = 8'h05;
  localparam logic [7:0] op_read_status_2    = 8'h35;
  localparam logic [7:0] op_read_status_3    = 8'h15;
  localparam logic [7:0] op_write_status_1   = 8'h01;
  localparam logic [7:0] op_write_status_2   = 8'h31;
  localparam logic [7:0] op_write_status_3   = 8'h11;
  localparam logic [7:0] op_read_data        = 8'h03;
  localparam logic [7:0] op_fast_read        = 8'h0b;
  localparam logic [7:0] op_set_read_param   = 8'hc0;
  // status bit positions
  localparam int busy_pos         = 0;   // status 1
  localparam int wel_pos          = 1;   // status 1
  localparam int quad_enable_pos  = 1;   // status 2
  // writable masks per status register
  localparam logic [7:0] sr1_write_mask = 8'hfc;
  localparam logic [7:0] sr2_write_mask = 8'hfb;
  localparam logic [7:0] sr3_write_mask = 8'hf0;
  // one-time bits in status 2: status_lock_bit_1 and security_lock_bits
  localparam logic [7:0] sr2_otp_mask   = 8'h39;
  // reset values
  localparam logic [7:0] sr_reset_value    = 8'h00;
  localparam logic [1:0] dummy_sel_reset   = 2'h0;
  // timing
  localparam int clk_period_ns      = 10;
  localparam int write_cycle_ns     = 5000000;
  localparam int write_cycle_cycles = write_cycle_ns / clk_period_ns;
  localparam int refresh_ns         = 50;
  localparam int refresh_cycles     = (refresh_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int single_dummy_clks  = 8;
  // command states
  typedef enum logic [2:0] {
    st_opcode, st_addr, st_dummy, st_data_out, st_data_in, st_ignore
  } cmd_state_type;
endpackage

// file: verilog/edge_sync.sv
// two-flop synchroniser with edge detection for the link pins
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter int               width       = 1,
  parameter logic [width-1:0] reset_level = '0  // idle pin levels, avoids false edges
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // raw pins
  input  wire logic [width-1:0] pin_in,
  // synchronised level and edges
  output logic      [width-1:0] level,
  output logic      [width-1:0] rise,
  output logic      [width-1:0] fall
);
  logic [width-1:0] meta_q;  // first stage, read only by second
  logic [width-1:0] sync_q;  // second stage
  logic [width-1:0] last_q;  // previous synced level

  // sample chain
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_q <= reset_level;
      sync_q <= reset_level;
      last_q <= reset_level;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;
endmodule // edge_sync
`default_nettype wire

// file: verilog/flash_cmd_seq.sv
// command sequencer: write enable, status read and write, basic and fast read
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_seq #(
  parameter int write_cycles = flash_cmd_pkg::write_cycle_cycles,
  parameter int addr_width   = 24
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        soft_reset,
  // serial link pins
  input  wire logic        chip_select_n,
  input  wire logic        serial_clk,
  input  wire logic [3:0]  serial_data_in,
  output logic      [3:0]  data_out,
  output logic      [3:0]  data_out_en,
  // mode control
  input  wire logic        four_wire_command_mode,
  // memory array read port
  output logic [addr_width-1:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  // status view
  output logic             busy,
  output logic             write_enable_latch,
  output logic [7:0]       status_1,
  output logic [7:0]       status_2,
  output logic [7:0]       status_3,
  output logic [1:0]       read_param_dummy_field
);
  // ************************************************************
  // pin synchronisation
  // ************************************************************
  logic [2:0] sync_lvl;  // synced cs, clk, io0
  logic [2:0] sync_rise; // rising edges
  logic [2:0] sync_fall; // falling edges
  logic [3:0] io_meta_q; // io lines first stage
  logic [3:0] io_q;      // io lines synced

  // chip select idles high, data line idles high, clock parked low
  edge_sync #(.width(3), .reset_level(3'b101)) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin_in  ({chip_select_n, serial_clk, serial_data_in[0]}),
    .level   (sync_lvl),
    .rise    (sync_rise),
    .fall    (sync_fall)
  );

  // four io lines for four-wire input
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      io_meta_q <= 4'h0;
      io_q      <= 4'h0;
    end else begin
      io_meta_q <= serial_data_in;
      io_q      <= io_meta_q;
    end
  end

  logic cs_active;  // chip select low
  logic sclk_rise;  // sample edge inside frame
  logic sclk_fall;  // shift edge inside frame
  logic cs_end;     // frame end
  assign cs_active = ~sync_lvl[2];
  assign sclk_rise = cs_active & sync_rise[1];
  assign sclk_fall = cs_active & sync_fall[1];
  assign cs_end    = sync_rise[2];

  // ************************************************************
  // shifter
  // ************************************************************
  logic [2:0] bits_per_clk;  // one or four lines
  assign bits_per_clk = four_wire_command_mode ? 3'h4 : 3'h1;

  flash_cmd_pkg::cmd_state_type state_q;
  logic [7:0]  rx_q;          // receive shift register, msb first
  logic [5:0]  bit_cnt_q;     // bits in current field
  logic [7:0]  opcode_q;      // captured opcode
  logic        op_valid_q;    // full opcode received
  logic [23:0] addr_q;        // address / stream pointer
  logic [7:0]  tx_q;          // transmit byte
  logic [3:0]  dummy_cnt_q;   // dummy clocks left
  logic [15:0] wdata_q;       // status write data
  logic [4:0]  wbits_q;       // status write bits received
  logic        vol_armed_q;   // 50h seen
  logic [7:0]  nv1_q, nv2_q, nv3_q;  // non-volatile copies
  logic [7:0]  sr1_q, sr2_q, sr3_q;  // active values
  logic [31:0] busy_cnt_q;    // write cycle timer
  logic        wel_q;         // write enable latch
  logic [1:0]  dummy_sel_q;   // read parameter field
  logic [7:0]  op_next;       // opcode after this edge
  logic        byte_done;     // a full byte completes

  assign op_next   = four_wire_command_mode ? {rx_q[3:0], io_q} : {rx_q[6:0], sync_lvl[0]};
  assign byte_done = (bit_cnt_q + 6'(bits_per_clk)) >= 6'd8;

  // status read selector, used only by the output shifter
  function automatic logic [7:0] status_sel(input logic [7:0] op, input logic [7:0] s1,
                                            input logic [7:0] s2, input logic [7:0] s3);
    case (op)
      flash_cmd_pkg::op_read_status_2: status_sel = s2;
      flash_cmd_pkg::op_read_status_3: status_sel = s3;
      default:                         status_sel = s1;
    endcase
  endfunction

  // dummy count by mode, mapping
  function automatic logic [3:0] dummy_count(input logic quad, input logic [1:0] sel);
    dummy_count = quad ? (4'({sel, 1'b0}) + 4'h2) : 4'(flash_cmd_pkg::single_dummy_clks);
  endfunction

  logic [7:0] sr_view1;  // status 1 with busy and latch
  assign sr_view1 = {sr1_q[7:2], wel_q, busy};

  // ************************************************************
  // command state machine
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!reset_n || soft_reset || cs_end || !cs_active) begin
      state_q    <= flash_cmd_pkg::st_opcode;
      rx_q       <= 8'h00;
      bit_cnt_q  <= 6'h00;
      op_valid_q <= 1'b0;
      dummy_cnt_q <= 4'h0;
      if (!reset_n || soft_reset) begin
        opcode_q <= 8'h00;
        addr_q   <= 24'h000000;
        wdata_q  <= 16'h0000;
        wbits_q  <= 5'h00;
      end else if (!cs_active && !cs_end) begin
        wbits_q <= 5'h00;
      end
    end else if (sclk_rise) begin
      case (state_q)
        flash_cmd_pkg::st_opcode: begin
          rx_q      <= op_next;
          bit_cnt_q <= bit_cnt_q + 6'(bits_per_clk);
          if (byte_done) begin
            opcode_q   <= op_next;
            op_valid_q <= 1'b1;
            bit_cnt_q  <= 6'h00;
            case (op_next)
              flash_cmd_pkg::op_read_status_1,
              flash_cmd_pkg::op_read_status_2,
              flash_cmd_pkg::op_read_status_3: begin
                state_q <= flash_cmd_pkg::st_data_out;
              end
              flash_cmd_pkg::op_read_data: begin
                if (!four_wire_command_mode && !busy)
                  state_q <= flash_cmd_pkg::st_addr;
                else
                  state_q <= flash_cmd_pkg::st_ignore;
              end
              flash_cmd_pkg::op_fast_read: begin
                state_q <= busy ? flash_cmd_pkg::st_ignore : flash_cmd_pkg::st_addr;
              end
              flash_cmd_pkg::op_write_status_1,
              flash_cmd_pkg::op_write_status_2,
              flash_cmd_pkg::op_write_status_3,
              flash_cmd_pkg::op_set_read_param: begin
                state_q <= flash_cmd_pkg::st_data_in;
                wbits_q <= 5'h00;
              end
              default: state_q <= flash_cmd_pkg::st_ignore;
            endcase
          end
        end
        flash_cmd_pkg::st_addr: begin
          addr_q    <= four_wire_command_mode ? {addr_q[19:0], io_q} : {addr_q[22:0], sync_lvl[0]};
          bit_cnt_q <= bit_cnt_q + 6'(bits_per_clk);
          if (bit_cnt_q + 6'(bits_per_clk) >= 6'd24) begin
            bit_cnt_q <= 6'h00;
            if (opcode_q == flash_cmd_pkg::op_fast_read) begin
              state_q     <= flash_cmd_pkg::st_dummy;
              dummy_cnt_q <= dummy_count(four_wire_command_mode, dummy_sel_q);
            end else begin
              state_q <= flash_cmd_pkg::st_data_out;
            end
          end
        end
        flash_cmd_pkg::st_dummy: begin
          // input during dummy clocks is ignored
          dummy_cnt_q <= dummy_cnt_q - 4'h1;
          if (dummy_cnt_q == 4'h1)
            state_q <= flash_cmd_pkg::st_data_out;
        end
        flash_cmd_pkg::st_data_in: begin
          if (wbits_q < 5'd16) begin
            wdata_q <= four_wire_command_mode ? {wdata_q[11:0], io_q}
                                              : {wdata_q[14:0], sync_lvl[0]};
            wbits_q <= wbits_q + 5'(bits_per_clk);
          end
        end
        flash_cmd_pkg::st_data_out: begin
          // stream pointer advances per byte on rising edge
          bit_cnt_q <= byte_done ? 6'h00 : bit_cnt_q + 6'(bits_per_clk);
          if (byte_done && (opcode_q == flash_cmd_pkg::op_read_data ||
                            opcode_q == flash_cmd_pkg::op_fast_read))
            addr_q <= addr_q + 24'h000001;
        end
        default: state_q <= state_q;
      endcase
    end
  end

  assign mem_addr = addr_q[addr_width-1:0];

  // ************************************************************
  // output shifter on falling edges
  // ************************************************************
  logic first_q;  // next falling edge loads a byte
  always_ff @(posedge mclk) begin
    if (!reset_n || !cs_active) begin
      tx_q        <= 8'h00;
      first_q     <= 1'b1;
      data_out    <= 4'h0;
      data_out_en <= 4'h0;
    end else if (sclk_fall && state_q == flash_cmd_pkg::st_data_out) begin
      logic [7:0] byte_v;
      byte_v = first_q || bit_cnt_q == 6'h00
             ? ((opcode_q == flash_cmd_pkg::op_read_data ||
                 opcode_q == flash_cmd_pkg::op_fast_read) ? mem_data
                : status_sel(opcode_q, sr_view1, sr2_q, sr3_q))
             : tx_q;
      first_q <= 1'b0;
      if (four_wire_command_mode) begin
        data_out    <= byte_v[7:4];
        tx_q        <= {byte_v[3:0], 4'h0};
        data_out_en <= 4'hf;
      end else begin
        data_out    <= {2'b00, byte_v[7], 1'b0};
        tx_q        <= {byte_v[6:0], 1'b0};
        data_out_en <= 4'h2;
      end
    end
  end

  // ************************************************************
  // status write decode at frame end
  // ************************************************************
  logic        is_wsr;       // frame was a status write
  logic        wsr_full;     // at least one byte
  logic        wsr_16;       // 01h carried two bytes
  logic        nv_ok;        // non-volatile write accepted
  logic        vol_ok;       // volatile write accepted
  logic [7:0]  b1, b2;       // first and second data bytes
  logic [7:0]  new1, new2, new3;
  logic [7:0]  qe_keep;      // quad enable mask in four-wire mode
  assign is_wsr = cs_end && op_valid_q &&
                  (opcode_q == flash_cmd_pkg::op_write_status_1 ||
                   opcode_q == flash_cmd_pkg::op_write_status_2 ||
                   opcode_q == flash_cmd_pkg::op_write_status_3);
  assign wsr_full = wbits_q >= 5'd8;
  assign wsr_16   = wbits_q >= 5'd16 && opcode_q == flash_cmd_pkg::op_write_status_1;
  assign b1 = wsr_16 ? wdata_q[15:8] : wdata_q[7:0];
  assign b2 = wdata_q[7:0];
  assign nv_ok  = is_wsr && wsr_full && wel_q && !vol_armed_q && !busy;
  assign vol_ok = is_wsr && wsr_full && vol_armed_q && !busy;
  assign qe_keep = four_wire_command_mode ? ~(8'h01 << flash_cmd_pkg::quad_enable_pos)
                                          : 8'hff;

  // merge writable bits, OTP bits only rise
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                       input logic [7:0] mask, input logic [7:0] otp);
    merge = ((old & ~mask) | (val & mask)) | (old & otp);
  endfunction

  always_comb begin
    new1 = sr1_q;
    new2 = sr2_q;
    new3 = sr3_q;
    case (opcode_q)
      flash_cmd_pkg::op_write_status_1: begin
        new1 = merge(sr1_q, b1, flash_cmd_pkg::sr1_write_mask, 8'h00);
        if (wsr_16)
          new2 = merge(sr2_q, b2, flash_cmd_pkg::sr2_write_mask & qe_keep,
                       flash_cmd_pkg::sr2_otp_mask);
      end
      flash_cmd_pkg::op_write_status_2:
        new2 = merge(sr2_q, b2, flash_cmd_pkg::sr2_write_mask & qe_keep,
                     flash_cmd_pkg::sr2_otp_mask);
      flash_cmd_pkg::op_write_status_3:
        new3 = merge(sr3_q, b2, flash_cmd_pkg::sr3_write_mask, 8'h00);
      default: ;
    endcase
  end

  // ************************************************************
  // status registers, latch, busy timer
  // ************************************************************
  logic [7:0] pend1_q, pend2_q, pend3_q;  // values held during write cycle
  logic [3:0] refresh_cnt_q;              // volatile refresh delay
  logic       vol_pend_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      nv1_q <= flash_cmd_pkg::sr_reset_value;
      nv2_q <= flash_cmd_pkg::sr_reset_value;
      nv3_q <= flash_cmd_pkg::sr_reset_value;
      sr1_q <= flash_cmd_pkg::sr_reset_value;
      sr2_q <= flash_cmd_pkg::sr_reset_value;
      sr3_q <= flash_cmd_pkg::sr_reset_value;
      pend1_q <= 8'h00;
      pend2_q <= 8'h00;
      pend3_q <= 8'h00;
      busy_cnt_q <= 32'h0;
      refresh_cnt_q <= 4'h0;
      vol_pend_q <= 1'b0;
    end else if (soft_reset) begin
      sr1_q <= nv1_q;
      sr2_q <= nv2_q;
      sr3_q <= nv3_q;
      refresh_cnt_q <= 4'h0;
      vol_pend_q <= 1'b0;
    end else begin
      if (nv_ok) begin
        pend1_q <= new1;
        pend2_q <= new2;
        pend3_q <= new3;
        busy_cnt_q <= 32'(write_cycles);
      end else if (busy_cnt_q == 32'h1) begin
        nv1_q <= pend1_q;
        nv2_q <= pend2_q;
        nv3_q <= pend3_q;
        sr1_q <= pend1_q;
        sr2_q <= pend2_q;
        sr3_q <= pend3_q;
        busy_cnt_q <= 32'h0;
      end else if (busy_cnt_q != 32'h0) begin
        busy_cnt_q <= busy_cnt_q - 32'h1;
      end
      if (vol_ok) begin
        pend1_q <= new1;
        pend2_q <= new2;
        pend3_q <= new3;
        refresh_cnt_q <= 4'(flash_cmd_pkg::refresh_cycles);
        vol_pend_q <= 1'b1;
      end else if (vol_pend_q) begin
        refresh_cnt_q <= refresh_cnt_q - 4'h1;
        if (refresh_cnt_q <= 4'h1) begin
          sr1_q <= pend1_q;
          sr2_q <= pend2_q;
          sr3_q <= pend3_q;
          vol_pend_q <= 1'b0;
        end
      end
    end
  end

  assign busy = busy_cnt_q != 32'h0;

  // write enable latch and volatile arm
  always_ff @(posedge mclk) begin
    if (!reset_n || soft_reset) begin
      wel_q       <= 1'b0;
      vol_armed_q <= 1'b0;
    end else if (cs_end && op_valid_q) begin
      case (opcode_q)
        flash_cmd_pkg::op_write_enable:    wel_q <= 1'b1;
        flash_cmd_pkg::op_write_disable:   wel_q <= 1'b0;
        flash_cmd_pkg::op_volatile_enable: vol_armed_q <= 1'b1;
        flash_cmd_pkg::op_write_status_1,
        flash_cmd_pkg::op_write_status_2,
        flash_cmd_pkg::op_write_status_3: begin
          if (vol_ok)
            vol_armed_q <= 1'b0;
        end
        default: ;
      endcase
    end else if (busy_cnt_q == 32'h1) begin
      wel_q <= 1'b0;
    end
  end

  // read parameter field
  always_ff @(posedge mclk) begin
    if (!reset_n || soft_reset)
      dummy_sel_q <= flash_cmd_pkg::dummy_sel_reset;
    else if (cs_end && op_valid_q && opcode_q == flash_cmd_pkg::op_set_read_param &&
             wbits_q >= 5'd8)
      dummy_sel_q <= wdata_q[5:4];
  end

  assign write_enable_latch     = wel_q;
  assign status_1               = sr_view1;
  assign status_2               = sr2_q;
  assign status_3               = sr3_q;
  assign read_param_dummy_field = dummy_sel_q;
endmodule // flash_cmd_seq
`default_nettype wire

// file: bench/flash_host_model.sv
// host-side serial link model driving frames and byte transfers
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  // clock
  input  wire logic       mclk,
  // link pins
  output logic            chip_select_n,
  output logic            serial_clk,
  output logic [3:0]      serial_data_in,
  input  wire logic [3:0] data_out
);
  // idle link: deselected, clock parked low
  initial begin
    chip_select_n  = 1'b1;
    serial_clk     = 1'b0;
    serial_data_in = 4'h5;
  end
  // open a frame
  task automatic start();
    @(posedge mclk);
    #1 chip_select_n = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  // shift n bits msb first, sampling the answer just before each rise
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      serial_data_in = {4{tx[i]}};
      repeat (8) @(posedge mclk);
      #1 rx[i] = data_out[1];
      serial_clk = 1'b1;
      repeat (8) @(posedge mclk);
      #1 serial_clk = 1'b0;
    end
  endtask
  // close a frame; released data line shows the inverse of its last value
  task automatic stop();
    repeat (8) @(posedge mclk);
    #1 chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    repeat (16) @(posedge mclk);
  endtask
endmodule // flash_host_model
`default_nettype wire

// file: bench/flash_cmd_seq_props.sv
// port-level timing relations of the command sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_seq_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       soft_reset,
  // link and status view
  input wire logic       chip_select_n,
  input wire logic [3:0] data_out_en,
  input wire logic       busy,
  input wire logic       write_enable_latch,
  input wire logic [7:0] status_1,
  input wire logic [7:0] status_2,
  input wire logic [7:0] status_3
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_idle_quiet; chip_select_n [*6] |-> data_out_en == 4'h0; endproperty
  property p_busy_view; busy == status_1[flash_cmd_pkg::busy_pos]; endproperty
  property p_wel_view; write_enable_latch == status_1[flash_cmd_pkg::wel_pos]; endproperty
  property p_wel_set; $rose(write_enable_latch) |-> chip_select_n; endproperty
  property p_busy_start; $rose(busy) |-> chip_select_n && write_enable_latch; endproperty
  property p_busy_hold; $rose(busy) |=> busy [*8]; endproperty
  property p_busy_end; $fell(busy) |-> ##[0:2] !write_enable_latch; endproperty
  property p_otp;
    !$past(soft_reset) && !$past(soft_reset, 2) |->
      (($past(status_2) & flash_cmd_pkg::sr2_otp_mask) & ~status_2) == 8'h00;
  endproperty
  property p_read_only;
    ((status_3 & ~flash_cmd_pkg::sr3_write_mask) == 8'h00) &&
      ((status_2 & ~flash_cmd_pkg::sr2_write_mask) == 8'h00);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("drive outside frame");
  a_busy_view: assert property (p_busy_view) else $error("busy view differs");
  a_wel_view: assert property (p_wel_view) else $error("latch view differs");
  a_wel_set: assert property (p_wel_set) else $error("latch set in frame");
  a_busy_start: assert property (p_busy_start) else $error("busy without latch");
  a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
  a_busy_end: assert property (p_busy_end) else $error("latch kept after cycle");
  a_otp: assert property (p_otp) else $error("one-time bit cleared");
  a_read_only: assert property (p_read_only) else $error("read-only bit set");
  c_busy: cover property ($rose(busy));
  c_wel: cover property ($rose(write_enable_latch));
  c_drive: cover property (data_out_en[1]);
endmodule // flash_cmd_seq_props
bind flash_cmd_seq flash_cmd_seq_props flash_cmd_seq_props_inst (.mclk, .reset_n, .soft_reset,
  .chip_select_n, .data_out_en, .busy, .write_enable_latch, .status_1, .status_2, .status_3);
`default_nettype wire

// file: bench/flash_cmd_seq_tb.sv
// self-checking bench of the command sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_seq_tb;
  // ****
  // signals
  // ****
  logic        mclk = 1'b0, reset_n = 1'b0, soft_reset = 1'b0, four_wire = 1'b0;
  logic        chip_select_n, serial_clk, busy, write_enable_latch;
  logic [3:0]  serial_data_in, data_out, data_out_en;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data, status_1, status_2, status_3, rx;
  logic [1:0]  read_param_dummy_field;
  int          mismatches = 0, checked = 0, cycles = 0;
  always #5 mclk = ~mclk;
  // array contents: address low byte xor a fixed pattern
  assign mem_data = mem_addr[7:0] ^ 8'h5a;
  flash_cmd_seq #(.write_cycles(600)) flash_cmd_seq_inst (.mclk(mclk), .reset_n(reset_n),
    .soft_reset(soft_reset), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .data_out(data_out), .data_out_en(data_out_en),
    .four_wire_command_mode(four_wire), .mem_addr(mem_addr), .mem_data(mem_data),
    .busy(busy), .write_enable_latch(write_enable_latch), .status_1(status_1),
    .status_2(status_2), .status_3(status_3), .read_param_dummy_field(read_param_dummy_field));
  flash_host_model flash_host_model_inst (.mclk(mclk), .chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in), .data_out(data_out));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("counts: %0d mismatches of %0d checks", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one frame of up to three bytes
  task automatic frame(input int n, input logic [7:0] b0, b1, b2);
    flash_host_model_inst.start();
    flash_host_model_inst.xfer(b0, 8, rx);
    if (n > 1) flash_host_model_inst.xfer(b1, 8, rx);
    if (n > 2) flash_host_model_inst.xfer(b2, 8, rx);
    flash_host_model_inst.stop();
  endtask
  // status read, two repeated bytes
  task automatic rd_status(input logic [7:0] op, input logic [7:0] exp);
    flash_host_model_inst.start();
    flash_host_model_inst.xfer(op, 8, rx);
    for (int k = 0; k < 2; k++) begin
      flash_host_model_inst.xfer(8'h00, 8, rx);
      chk(rx, exp, "status byte");
    end
    flash_host_model_inst.stop();
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge mclk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic test_latch();
    chk(read_param_dummy_field, 2'h0, "dummy default");
    frame(1, flash_cmd_pkg::op_write_enable, 0, 0);
    chk(write_enable_latch, 1'b1, "latch set");
    frame(1, flash_cmd_pkg::op_write_disable, 0, 0);
    chk(write_enable_latch, 1'b0, "latch clear");
    flash_host_model_inst.start();
    flash_host_model_inst.xfer(flash_cmd_pkg::op_write_enable, 4, rx);
    flash_host_model_inst.stop();
    chk(write_enable_latch, 1'b0, "partial opcode");
    $display("latch test done");
  endtask
  task automatic test_nv();
    frame(2, flash_cmd_pkg::op_write_status_1, 8'h1c, 0);
    chk(status_1, 8'h00, "write without latch");
    frame(1, flash_cmd_pkg::op_write_enable, 0, 0);
    frame(3, flash_cmd_pkg::op_write_status_1, 8'h1c, 8'h02);
    flash_host_model_inst.start();
    flash_host_model_inst.xfer(flash_cmd_pkg::op_read_status_1, 8, rx);
    flash_host_model_inst.xfer(8'h00, 8, rx);
    flash_host_model_inst.stop();
    chk(rx & 8'h03, 8'h03, "busy poll");
    wait_idle();
    chk(status_1, 8'h1c, "status 1 after cycle");
    chk(status_2, 8'h02, "second byte");
    rd_status(flash_cmd_pkg::op_read_status_1, 8'h1c);
    frame(1, flash_cmd_pkg::op_write_enable, 0, 0);
    frame(2, flash_cmd_pkg::op_write_status_1, 8'h24, 0);
    wait_idle();
    chk(status_2, 8'h02, "one byte write");
    chk(status_1, 8'h24, "status 1 only");
    chk(write_enable_latch, 1'b0, "latch after cycle");
    $display("non-volatile test done");
  endtask
  task automatic test_vol();
    frame(1, flash_cmd_pkg::op_volatile_enable, 0, 0);
    chk(write_enable_latch, 1'b0, "arm keeps latch");
    frame(2, flash_cmd_pkg::op_write_status_3, 8'hff, 0);
    chk(status_3, 8'hf0, "volatile mask");
    chk({write_enable_latch, busy}, 2'h0, "volatile quiet");
    frame(1, flash_cmd_pkg::op_volatile_enable, 0, 0);
    frame(2, flash_cmd_pkg::op_write_status_2, 8'h08, 0);
    frame(1, flash_cmd_pkg::op_volatile_enable, 0, 0);
    frame(2, flash_cmd_pkg::op_write_status_2, 8'h00, 0);
    rd_status(flash_cmd_pkg::op_read_status_2, 8'h08);
    rd_status(flash_cmd_pkg::op_read_status_3, 8'hf0);
    frame(2, flash_cmd_pkg::op_set_read_param, 8'h30, 0);
    chk(read_param_dummy_field, 2'h3, "dummy field set");
    @(posedge mclk);
    #1 soft_reset = 1'b1;
    @(posedge mclk);
    #1 soft_reset = 1'b0;
    repeat (4) @(posedge mclk);
    chk(status_2, 8'h02, "reload 2");
    chk(status_3, 8'h00, "reload 3");
    chk(read_param_dummy_field, 2'h0, "dummy after reset");
    $display("volatile test done");
  endtask
  task automatic test_read(input logic [7:0] op, input logic [7:0] lo, input int dum);
    flash_host_model_inst.start();
    flash_host_model_inst.xfer(op, 8, rx);
    flash_host_model_inst.xfer(8'h00, 8, rx);
    flash_host_model_inst.xfer(8'h01, 8, rx);
    flash_host_model_inst.xfer(lo, 8, rx);
    if (dum > 0) flash_host_model_inst.xfer(8'ha5, 8, rx);
    for (int k = 0; k < 2; k++) begin
      flash_host_model_inst.xfer(8'h00, 8, rx);
      chk(rx, (lo + k[7:0]) ^ 8'h5a, "read byte");
    end
    flash_host_model_inst.stop();
    $display("read test done");
  endtask
  // ****
  // main sequence and timeout
  // ****
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    test_latch();
    test_nv();
    test_vol();
    test_read(flash_cmd_pkg::op_read_data, 8'h10, 0);
    test_read(flash_cmd_pkg::op_fast_read, 8'hf0, 8);
    print_verdict();
  end
endmodule // flash_cmd_seq_tb
`default_nettype wire
